/* src/sirq_host.sv */
/*
 host end of the serialized interrupt line: frames cycles, samples
 channels into irq levels, cascades slave pic, scans pci channels.
 assumes an open-drain line with external pull-up; oe high drives low.
*/
`timescale 1ns/10ps
`default_nettype none
module sirq_host
  import sirq_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_continuous,
  input  wire logic [5:0]  i_channels,
  input  wire logic        i_line_in,
  output logic             o_line_out,
  output logic             o_line_oe,
  output logic [15:0]      o_irq_level,
  output logic [PCI_CHANNELS-1:0] o_pci_level,
  output logic [7:0]       o_primary_req,
  output logic             o_cycle_done
);
  sirq_state_e  state_q;
  sirq_state_e  state_d;
  logic [2:0]   phase_q;
  logic [5:0]   chan_q;
  logic [5:0]   nchan_q;
  logic [31:0]  sample_q;
  logic         prev_q;
  logic         line_s;
  logic         slave_start;
  logic         last_phase;
  logic         last_chan;
  logic [5:0]   nchan_clip;
  logic [15:0]  irq_true;
  logic [7:0]   prim_in;
  logic         sample_now;
  logic         own_echo;
  logic         turn_q;
  logic [SYNC_LAT-1:0]   strobe_dly_q;
  logic [SYNC_LAT-1:0]   oe_dly_q;
  logic [5*SYNC_LAT-1:0] idx_dly_q;

  sirq_sync u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_pin   (i_line_in),
    .o_level (line_s)
  );

  // a slave pulls the idle line low to wake us in quiet mode
  // our own start and stop come back through the synchroniser late;
  // without this blanking the stop frame would wake us in quiet mode
  assign own_echo    = o_line_oe || (|oe_dly_q);
  assign slave_start = !i_continuous && prev_q && !line_s &&
                       !own_echo;
  // channel count clamped so the frame never drops under the minimum
  assign nchan_clip = (i_channels < 6'(MIN_CHANNELS)) ? 6'(MIN_CHANNELS) :
                      (i_channels > 6'(MAX_CHANNELS)) ? 6'(MAX_CHANNELS) :
                      i_channels;
  assign last_chan  = (chan_q == nchan_q - 6'd1);

  always_comb begin
    last_phase = 1'b0;
    unique case (state_q)
      SIRQ_START: last_phase = (phase_q == 3'(START_CLKS - 1));
      SIRQ_STOP:  last_phase = (phase_q == 3'(STOP_CLKS - 1));
      SIRQ_SLOT:  last_phase = (phase_q == 3'(SLOT_CLKS - 1));
      SIRQ_TURN:  last_phase = 1'b1;
      SIRQ_IDLE:  last_phase = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SIRQ_IDLE:  if (i_continuous || slave_start) state_d = SIRQ_START;
      SIRQ_START: if (last_phase) state_d = SIRQ_SLOT;
      SIRQ_SLOT:  if (last_phase && last_chan) state_d = SIRQ_STOP;
      SIRQ_STOP:  if (last_phase) state_d = SIRQ_TURN;
      SIRQ_TURN:  state_d = SIRQ_IDLE;
      default:    state_d = SIRQ_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= SIRQ_IDLE;
      phase_q <= 3'h0;
      chan_q  <= 6'h00;
      nchan_q <= CHANNELS_RST;
      prev_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      prev_q  <= line_s;
      phase_q <= (state_q != state_d || last_phase) ? 3'h0 : phase_q + 3'h1;
      if (state_q == SIRQ_IDLE) begin
        chan_q  <= 6'h00;
        nchan_q <= nchan_clip;
      end else if (state_q == SIRQ_SLOT && last_phase) begin
        chan_q <= chan_q + 6'h01;
      end
    end
  end

  // sample in the middle clock of each slot; a low line means asserted.
  // line_s trails the pin by the synchroniser, so the strobe and its
  // channel index are delayed by the same count before they are used
  assign sample_now = (state_q == SIRQ_SLOT) && (phase_q == 3'h1);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sample_q     <= 32'h0000_0000;
      strobe_dly_q <= '0;
      idx_dly_q    <= '0;
      oe_dly_q     <= '0;
    end else begin
      strobe_dly_q <= {strobe_dly_q[SYNC_LAT-2:0], sample_now};
      idx_dly_q    <= {idx_dly_q[5*SYNC_LAT-6:0], chan_q[4:0]};
      oe_dly_q     <= {oe_dly_q[SYNC_LAT-2:0], o_line_oe};
      if (strobe_dly_q[SYNC_LAT-1]) begin
        sample_q[idx_dly_q[5*SYNC_LAT-1 -: 5]] <= !line_s;
      end
    end
  end

  // host drives start low in continuous mode; in quiet mode it only
  // extends a slave-begun start, as the slave drives the first clocks
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_line_out <= 1'b0;
      o_line_oe  <= 1'b0;
    end else begin
      o_line_out <= 1'b0;
      o_line_oe  <= (state_d == SIRQ_START) ||
                    (state_d == SIRQ_STOP);
    end
  end

  // rtc level is active low: invert so all irq_level bits are active high
  assign irq_true = sample_q[15:0] ^ ACTIVE_LOW_MAP;
  // slave pic output ties into primary input 2
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_prim
      if (g == CASCADE_LEVEL) begin : g_casc
        assign prim_in[g] = |irq_true[15:8];
      end else begin : g_direct
        assign prim_in[g] = irq_true[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_irq_level   <= 16'h0000;
      o_pci_level   <= 16'h0000;
      o_primary_req <= 8'h00;
      o_cycle_done  <= 1'b0;
      turn_q        <= 1'b0;
    end else begin
      // one clock after turn, so the last slot's delayed sample is in
      turn_q       <= (state_q == SIRQ_TURN);
      o_cycle_done <= turn_q;
      if (turn_q) begin
        o_irq_level   <= irq_true;
        o_pci_level   <= sample_q[31:16] & {16{nchan_q == 6'(MAX_CHANNELS)}};
        o_primary_req <= prim_in;
      end
    end
  end

  property p_frame_len;
    @(posedge i_clk) disable iff (i_srst)
      (state_q == SIRQ_START && $past(state_q) == SIRQ_IDLE) |->
        ##4 state_q == SIRQ_SLOT;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("start len");
  property p_min_chan;
    @(posedge i_clk) disable iff (i_srst)
      (state_q == SIRQ_SLOT && state_d == SIRQ_STOP) |->
        chan_q >= 6'(MIN_CHANNELS - 1);
  endproperty
  a_min_chan: assert property (p_min_chan) else $error("too few");
  property p_max_chan;
    @(posedge i_clk) disable iff (i_srst) nchan_q <= 6'(MAX_CHANNELS);
  endproperty
  a_max_chan: assert property (p_max_chan) else $error("too many");
  property p_cont_start;
    @(posedge i_clk) disable iff (i_srst)
      (state_q == SIRQ_IDLE && i_continuous) |=> o_line_oe;
  endproperty
  a_cont_start: assert property (p_cont_start) else $error("no start");
  property p_quiet;
    @(posedge i_clk) disable iff (i_srst)
      (state_q == SIRQ_IDLE && !i_continuous && !slave_start) |=> !o_line_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet drive");
  property p_ascend;
    @(posedge i_clk) disable iff (i_srst)
      (state_q == SIRQ_SLOT && last_phase && !last_chan) |=>
        chan_q == $past(chan_q) + 6'd1;
  endproperty
  a_ascend: assert property (p_ascend) else $error("order");
  property p_idle_after;
    @(posedge i_clk) disable iff (i_srst)
      state_q == SIRQ_TURN |=>
        state_q == SIRQ_IDLE ##1 o_cycle_done ##1 !o_cycle_done;
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("idle");
  property p_cascade;
    @(posedge i_clk) disable iff (i_srst)
      o_primary_req[CASCADE_LEVEL] == (|o_irq_level[15:8]);
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade");
  property p_rtc_low;
    @(posedge i_clk) disable iff (i_srst)
      state_q == SIRQ_TURN |=>
        ##1 o_irq_level[IRQ_RTC] == !$past(sample_q[IRQ_RTC]);
  endproperty
  a_rtc_low: assert property (p_rtc_low) else $error("rtc pol");
  property p_pci;
    @(posedge i_clk) disable iff (i_srst)
      (nchan_q != 6'(MAX_CHANNELS) && state_q == SIRQ_TURN) |=>
        ##1 o_pci_level == 16'h0000;
  endproperty
  a_pci: assert property (p_pci) else $error("pci");
  c_cont: cover property (@(posedge i_clk) state_q == SIRQ_TURN && i_continuous);
  c_quiet: cover property (@(posedge i_clk) slave_start);
  c_full: cover property (@(posedge i_clk) o_cycle_done && nchan_q == 6'(MAX_CHANNELS));
endmodule
`default_nettype wire

/* src/sirq_pkg.sv */
/*
 serial interrupt frame constants: frame counts, channel map, states.
 assumes a 125 mhz clock and a shared open-drain line with pull-up.
*/
package sirq_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned MIN_CHANNELS   = 17;
  localparam int unsigned MAX_CHANNELS   = 32;
  localparam int unsigned START_CLKS     = 4;
  localparam int unsigned STOP_CLKS      = 2;
  localparam int unsigned SLOT_CLKS      = 3;
  localparam int unsigned SYNC_LAT       = 4;
  localparam int unsigned PCI_CHANNELS   = 16;
  localparam int unsigned CASCADE_LEVEL  = 2;
  localparam int unsigned IRQ_KEYBOARD   = 1;
  localparam int unsigned IRQ_SERIAL_A   = 3;
  localparam int unsigned IRQ_SERIAL_B   = 4;
  localparam int unsigned IRQ_FLOPPY     = 6;
  localparam int unsigned IRQ_RTC        = 8;
  localparam int unsigned IRQ_MOUSE      = 12;
  localparam int unsigned IRQ_IDE        = 14;
  localparam logic [15:0] ACTIVE_LOW_MAP = 16'h0100;
  localparam logic [5:0]  CHANNELS_RST   = 6'h11;

  typedef enum logic [2:0] {
    SIRQ_IDLE  = 3'b000,
    SIRQ_START = 3'b001,
    SIRQ_SLOT  = 3'b010,
    SIRQ_STOP  = 3'b011,
    SIRQ_TURN  = 3'b100
  } sirq_state_e;
endpackage

/* src/sirq_sync.sv */
/*
 three-flop synchroniser with agreement filter for a pin input.
 assumes the pin is asynchronous to i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module sirq_sync (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // first stage read only by the second; reset to the idle-high line
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      o_level <= 1'b1;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/sirq_slave_model.sv */
/*
 slave model on the serialized interrupt line: drives request slots.
 assumes a pull-up on the line and the host's start and stop framing.
*/
`timescale 1ns/10ps
`default_nettype none
module sirq_slave_model (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_line,
  input  wire logic        i_kick,
  input  wire logic [5:0]  i_nch,
  input  wire logic [31:0] i_req,
  output logic             o_oe
);
  logic [2:0] ph_q;
  logic [2:0] kick_q;
  int         cnt_q;
  // start is held past the host's synchroniser lag so its takeover
  // leaves no gap; slots then count from the start release
  assign o_oe = (kick_q != 3'h0) || (ph_q == 3'h2 && i_req[cnt_q/3]);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ph_q   <= 3'h0;
      kick_q <= 3'h0;
      cnt_q  <= 0;
    end else begin
      if (i_kick) begin
        kick_q <= 3'h5;
      end else if (kick_q != 3'h0) begin
        kick_q <= kick_q - 3'h1;
      end
      case (ph_q)
        3'h0: if (!i_line) ph_q <= 3'h1;
        3'h1: if (i_line) begin
          ph_q  <= 3'h2;
          cnt_q <= 0;
        end
        3'h2: begin
          cnt_q <= cnt_q + 1;
          if (cnt_q >= 3 * i_nch - 1) ph_q <= 3'h3;
        end
        3'h3: if (!i_line) ph_q <= 3'h4;
        default: if (i_line) ph_q <= 3'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* sim/serial_irq_frame_logic_tb_top.sv */
/*
 testbench for the serialized interrupt host: framing, levels, modes.
 assumes a pull-up on the line and one slave model sharing it.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_irq_frame_logic_tb_top;
  import sirq_pkg::*;
  logic        clk, srst, cont, kick, h_out, h_oe, s_oe, done, line;
  logic [5:0]  chs, nch;
  logic [31:0] req;
  logic [15:0] irq, pci;
  logic [7:0]  prim;
  int          miscompares, checks_done, cyc;
  assign line = !(h_oe && !h_out) && !s_oe;
  sirq_host dut (.i_clk(clk), .i_srst(srst), .i_continuous(cont),
    .i_channels(chs), .i_line_in(line), .o_line_out(h_out),
    .o_line_oe(h_oe), .o_irq_level(irq), .o_pci_level(pci),
    .o_primary_req(prim), .o_cycle_done(done));
  sirq_slave_model slv (.i_clk(clk), .i_srst(srst), .i_line(line),
    .i_kick(kick), .i_nch(nch), .i_req(req), .o_oe(s_oe));
  task automatic check(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_done;
    repeat (400) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) return;
    end
    check("cycle_done", 32'h0, 32'h1);
  endtask
  task automatic judge(input logic [5:0] n, input logic [31:0] r);
    logic [15:0] lv;
    logic [7:0]  pr;
    lv = r[15:0] ^ ACTIVE_LOW_MAP;
    pr = lv[7:0];
    pr[CASCADE_LEVEL] = |lv[15:8];
    check("irq", {16'h0, irq}, {16'h0, lv});
    check("pci", {16'h0, pci}, n == 6'h20 ? {16'h0, r[31:16]} : 0);
    check("primary", {24'h0, prim}, {24'h0, pr});
  endtask
  // quiet idle between runs keeps the slave's slot count in step
  task automatic t_cont(input logic [5:0] ch, n, input logic [31:0] r);
    @(posedge clk);
    cont <= 1'b1;
    chs  <= ch;
    nch  <= n;
    req  <= r;
    wait_done;
    judge(n, r);
    wait_done;
    judge(n, r);
    @(posedge clk);
    cont <= 1'b0;
    repeat (150) @(posedge clk);
  endtask
  task automatic t_map;
    int lvl[7] = '{IRQ_KEYBOARD, IRQ_SERIAL_A, IRQ_SERIAL_B, IRQ_FLOPPY,
                   IRQ_RTC, IRQ_MOUSE, IRQ_IDE};
    foreach (lvl[i]) t_cont(6'h11, 6'h11, 32'h1 << lvl[i]);
  endtask
  task automatic t_quiet;
    int seen;
    seen = 0;
    @(posedge clk);
    req <= 32'h0000_1002;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) seen++;
    end
    check("quiet_idle", 32'(seen), 32'h0);
    @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    wait_done;
    judge(6'h11, 32'h0000_1002);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    {srst, cont, kick, chs, nch, req} = {3'b100, 6'h11, 6'h11, 32'h0};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("idle_oe", {31'h0, h_oe}, 32'h0);
    check("line_out", {31'h0, h_out}, 32'h0);
    t_cont(6'h11, 6'h11, 32'h0000_5A5A);
    t_cont(6'h3F, 6'h20, 32'hA5C3_8001);
    t_cont(6'h05, 6'h11, 32'hFFFF_0104);
    t_map;
    t_quiet;
    complete_run;
  end
endmodule
`default_nettype wire
